// *** include/ica_params.svh ***
/*
  constants for the serial clock arbitration block: reload field
  position, counter reset value, link clock figure.
  assumes it is included by bare name into the arbiter design file.
*/
// What this block does
// RQ1: release line high on receive, transmit, restart, stop
// RQ2: counter frozen until released line sampled high
// RQ3: on first high sample load low seven reload bits
// RQ4: high phase lasts one rollover from seen high
// RQ5: counter steps each clock; rollover ends phase
`ifndef ICA_PARAMS_SVH
`define ICA_PARAMS_SVH

// ==========================================================
// reload field and counter
`define ICA_RELOAD_W 8
`define ICA_RELOAD_MSB 6
`define ICA_RELOAD_LSB 0
`define ICA_CNT_W 7
`define ICA_CNT_RST 7'h00

// ==========================================================
// link clock
`define ICA_LINK_PERIOD_NS 125

`endif

// *** include/ica_pkg.sv ***
/*
  types for the serial clock arbitration block.
  assumes nothing of its surroundings.
*/
package ica_pkg;

  // ========================================================
  // phase states, one-hot
  typedef enum logic [3:0] {
    ICA_IDLE = 4'h1,
    ICA_LOW = 4'h2,
    ICA_WAIT = 4'h4,
    ICA_HIGH = 4'h8
  } ica_state_type;

endpackage

// *** verilog/ica_sync.sv ***
/*
  two-flop level synchroniser.
  assumes an asynchronous, active-high reset.
*/
`timescale 1ns/100ps
module ica_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);

  logic stage1;
  logic next_stage1;
  logic next_dout;

  always_comb begin
    next_stage1 = din;
    next_dout = stage1;
  end

  // the first stage feeds only the second one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      stage1 <= next_stage1;
      dout <= next_dout;
    end
  end

endmodule

// *** verilog/ica_arbiter.sv ***
/*
  clock arbitration for the serial master: times each clock phase
  with the rate_counter and holds it while a slave stretches the line.
  assumes the sequencer issues one phase request at a time, in idle,
  and the reload value comes from the core clock domain.
*/
`timescale 1ns/100ps
`include "ica_params.svh"
module ica_arbiter #(
  parameter int CNT_W = `ICA_CNT_W
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic linkClk,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic [`ICA_RELOAD_W-1:0] reloadValue,
  input wire logic lowReq,
  input wire logic releaseReq,
  output logic phaseDone,
  output logic waiting,
  output logic [CNT_W-1:0] rateCounter
);

  // ========================================================
  // line sampling: pin caught on the link clock, then crossed
  logic sclLink;
  logic sclHigh;

  ica_sync #(.RST_VAL(1'b1)) u_pin_sync (
    .clk(linkClk),
    .rst(rst),
    .din(sclIn),
    .dout(sclLink)
  );

  // link clock may stop; the level is crossed, never an edge
  ica_sync #(.RST_VAL(1'b1)) u_core_sync (
    .clk(core_clk),
    .rst(rst),
    .din(sclLink),
    .dout(sclHigh)
  );

  // ========================================================
  // phase sequencer and rate counter
  ica_pkg::ica_state_type state;
  ica_pkg::ica_state_type next_state;
  logic [CNT_W-1:0] next_rateCounter;
  logic next_sclOe;
  logic next_phaseDone;
  logic next_waiting;
  logic [CNT_W-1:0] reloadBits;

  assign reloadBits =
    CNT_W'(reloadValue[`ICA_RELOAD_MSB:`ICA_RELOAD_LSB]);

  always_comb begin
    next_state = state;
    next_rateCounter = rateCounter;
    next_sclOe = sclOe;
    next_phaseDone = 1'b0;
    case (state)
      ica_pkg::ICA_IDLE: begin
        if (lowReq) begin
          next_state = ica_pkg::ICA_LOW;
          next_sclOe = 1'b1;
          next_rateCounter = reloadBits;
        end else if (releaseReq) begin
          next_state = ica_pkg::ICA_WAIT; // RQ1
          next_sclOe = 1'b0; // RQ1
        end
      end
      ica_pkg::ICA_LOW: begin
        if (rateCounter == '0) begin
          next_state = ica_pkg::ICA_IDLE; // RQ5
          next_phaseDone = 1'b1;
        end else begin
          next_rateCounter = rateCounter - CNT_W'(1); // RQ5
        end
      end
      ica_pkg::ICA_WAIT: begin
        // counter held: a stretching slave costs no high time
        // limitation: the sampled level trails the pin by up to two
        // link periods plus two core cycles, so a shorter low phase can let a stale high in
        if (sclHigh) begin
          next_state = ica_pkg::ICA_HIGH; // RQ2
          next_rateCounter = reloadBits; // RQ3
        end
      end
      ica_pkg::ICA_HIGH: begin
        if (rateCounter == '0) begin
          next_state = ica_pkg::ICA_IDLE; // RQ4
          next_phaseDone = 1'b1; // RQ5
        end else begin
          next_rateCounter = rateCounter - CNT_W'(1); // RQ5
        end
      end
      default: begin
        next_state = ica_pkg::ICA_IDLE;
        next_sclOe = 1'b0;
        next_rateCounter = CNT_W'(`ICA_CNT_RST);
      end
    endcase
    next_waiting = (next_state == ica_pkg::ICA_WAIT);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= ica_pkg::ICA_IDLE;
      rateCounter <= CNT_W'(`ICA_CNT_RST);
      sclOe <= 1'b0;
      sclOut <= 1'b0;
      phaseDone <= 1'b0;
      waiting <= 1'b0;
    end else begin
      state <= next_state;
      rateCounter <= next_rateCounter;
      sclOe <= next_sclOe;
      sclOut <= 1'b0;
      phaseDone <= next_phaseDone;
      waiting <= next_waiting;
    end
  end

  // ========================================================
  // checks
  logic [CNT_W:0] highCycles;
  logic [CNT_W-1:0] loadVal;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      highCycles <= '0;
      loadVal <= '0;
    end else if (state == ica_pkg::ICA_WAIT) begin
      highCycles <= '0;
      loadVal <= reloadBits;
    end else if (state == ica_pkg::ICA_HIGH) begin
      highCycles <= highCycles + (CNT_W+1)'(1);
    end
  end

  a_release_line: assert property ( // RQ1
    @(posedge core_clk) disable iff (rst)
    (state == ica_pkg::ICA_WAIT || state == ica_pkg::ICA_HIGH) |-> !sclOe)
    else $error("line driven low during release");

  a_frozen_wait: assert property ( // RQ2
    @(posedge core_clk) disable iff (rst)
    state == ica_pkg::ICA_WAIT && $past(state == ica_pkg::ICA_WAIT)
    |-> $stable(rateCounter))
    else $error("counter moved while waiting for high");

  a_wait_holds: assert property ( // RQ2
    @(posedge core_clk) disable iff (rst)
    state == ica_pkg::ICA_WAIT && !sclHigh |=> state == ica_pkg::ICA_WAIT)
    else $error("left wait before line sampled high");

  a_reload_load: assert property ( // RQ3
    @(posedge core_clk) disable iff (rst)
    state == ica_pkg::ICA_WAIT && sclHigh
    |=> state == ica_pkg::ICA_HIGH && rateCounter == $past(reloadBits))
    else $error("counter not loaded from reload bits");

  a_high_length: assert property ( // RQ4
    @(posedge core_clk) disable iff (rst)
    state == ica_pkg::ICA_HIGH && rateCounter == '0
    |-> highCycles == {1'b0, loadVal})
    else $error("high phase shorter than one rollover");

  a_count_step: assert property ( // RQ5
    @(posedge core_clk) disable iff (rst)
    state == ica_pkg::ICA_HIGH && rateCounter != '0
    |=> rateCounter == $past(rateCounter) - CNT_W'(1))
    else $error("counter did not step by one");

  a_done_rollover: assert property ( // RQ5
    @(posedge core_clk) disable iff (rst)
    (state == ica_pkg::ICA_HIGH || state == ica_pkg::ICA_LOW)
    && rateCounter == '0 |=> phaseDone ##1 !phaseDone)
    else $error("rollover did not end the phase");

  a_drive_low: assert property ( // RQ1
    @(posedge core_clk) disable iff (rst)
    state == ica_pkg::ICA_LOW |-> sclOe && waiting == 1'b0)
    else $error("low phase not driving the line");

  c_stretch: cover property (
    @(posedge core_clk) disable iff (rst)
    state == ica_pkg::ICA_WAIT [*4] ##1 state == ica_pkg::ICA_HIGH);

  c_high_done: cover property (
    @(posedge core_clk) disable iff (rst)
    state == ica_pkg::ICA_HIGH ##1 phaseDone);

  c_low_done: cover property (
    @(posedge core_clk) disable iff (rst)
    state == ica_pkg::ICA_LOW ##1 phaseDone);

endmodule

// *** tb/ica_slave_model.sv ***
/*
  far-side device on the serial clock wire: a slave that may hold
  the line low to stretch it.
  assumes a pull-up on the wire; the master only ever pulls low.
*/
`timescale 1ns/100ps
module ica_slave_model (
  input wire logic sclOe,
  input wire logic holdLow,
  output logic sclLine
);
  // ========================================================
  // wired-and line
  // released by both parties, the pull-up wins
  assign sclLine = !(sclOe || holdLow);
endmodule

// *** tb/i2c_master_clock_arbitration_test.sv ***
/*
  self-checking bench for the clock arbitration block.
  assumes the design and the slave model are compiled before it.
*/
`timescale 1ns/100ps
module i2c_master_clock_arbitration_test;
  logic core_clk = 0, linkClk = 0, rst = 1;
  logic lowReq = 0, releaseReq = 0, holdLow = 0;
  logic sclIn, sclOut, sclOe, phaseDone, waiting;
  logic [7:0] reloadValue = 8'h00;
  logic [7:0] n;
  logic [6:0] rateCounter;
  int fails = 0, comparisons = 0, ticks = 0;

  // ========================================================
  // clocks, parts
  initial forever #5 core_clk = ~core_clk;
  initial begin
    #3;
    forever #62.5 linkClk = ~linkClk;
  end
  ica_arbiter i_dut (.core_clk(core_clk), .rst(rst), .linkClk(linkClk),
    .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe),
    .reloadValue(reloadValue), .lowReq(lowReq),
    .releaseReq(releaseReq), .phaseDone(phaseDone),
    .waiting(waiting), .rateCounter(rateCounter));
  ica_slave_model i_slave (.sclOe(sclOe), .holdLow(holdLow),
    .sclLine(sclIn));

  // ========================================================
  // shared tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task close_out;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // cut a hang short; the whole run needs well under 1000 cycles
  always @(posedge core_clk) begin
    ticks++;
    if (ticks == 5000) begin
      fails++;
      close_out;
    end
  end

  // one phase; k = cycles from counter load to phaseDone
  task run(input logic low, input logic [7:0] rv, output logic [7:0] k);
    logic [6:0] held;
    @(posedge core_clk);
    reloadValue <= rv;
    lowReq <= low;
    releaseReq <= !low;
    @(posedge core_clk);
    lowReq <= 0;
    releaseReq <= 0;
    #1 held = rateCounter;
    k = 0;
    while (waiting === 1'b1 && k < 250) begin
      chk(8'(rateCounter), 8'(held));
      chk(8'(sclOe), 8'h00);
      @(posedge core_clk);
      #1 k++;
    end
    chk(8'(rateCounter), 8'(rv[6:0]));
    k = 0;
    while (phaseDone !== 1'b1 && k < 250) begin
      @(posedge core_clk);
      #1 k++;
    end
    chk(8'(sclOe), 8'(low));
    chk(8'(sclOut), 8'h00);
  endtask

  // ========================================================
  // scenarios
  task t_low;
    run(1'b1, 8'h82, n);
    chk(n, 8'h03);
    $display("test low phase done");
  endtask

  task t_high;
    run(1'b0, 8'h05, n);
    chk(n, 8'h06);
    $display("test high phase done");
  endtask

  // slave pulls the line low before a long low phase so the sampled level is low before
  // the release; then it stretches far longer than the sync delay
  task t_stretch;
    @(posedge core_clk);
    holdLow <= 1;
    run(1'b1, 8'hFF, n);
    chk(n, 8'h80);
    fork
      run(1'b0, 8'hFF, n);
      begin
        repeat (150) @(posedge core_clk);
        #1 chk(8'(waiting), 8'h01);
        holdLow <= 0;
      end
    join
    chk(n, 8'h80);
    $display("test stretch done");
  endtask

  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 0;
    t_low;
    t_high;
    t_stretch;
    close_out;
  end
endmodule
